// ==== prbd_ring_dma.sv ====
// Purpose: Receive page ring DMA, frame header writer and transmit fetch
// Assumes: MAC receive bytes arrive at most one per cycle, 3+ idle cycles between frames
// Notes: Packet memory lives here; host reaches it through the data port
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/10ps
module prbd_ring_dma
  import prbd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_last,
  input wire logic rx_crc_err,
  input wire logic rx_align_err,
  input wire logic rx_mii_err,
  input wire logic rx_mcast,
  output logic rx_accept_pulse,
  output logic rx_drop_pulse,
  output logic [7:0] tx_line_data,
  output logic tx_line_valid,
  input wire logic tx_line_ready
);
  import prbd_pkg::*;

  typedef enum logic [2:0] {RX_IDLE, RX_STORE, RX_DROP, RX_END, RX_HDR0, RX_HDR1} prbd_rx_e;
  typedef enum logic [1:0] {TX_IDLE, TX_LOAD, TX_SEND, TX_WAIT} prbd_tx_e;

  logic [15:0] mem [PRBD_MEM_WORDS];

  logic [7:0] ring_first_page_reg, ring_stop_page_reg, read_page_reg, write_page_pointer_reg;
  logic [7:0] tx_first_page_reg, tx_length_low_reg, tx_length_high_reg, tx_end_page_report_reg;
  logic [15:0] host_addr_reg;
  logic [1:0] rx_config_reg;
  logic tx_ring_en_reg, queue_en_reg;
  logic host_pend_reg;
  logic [PRBD_WADDR_W-1:0] host_pend_addr_reg;
  logic [15:0] host_pend_data_reg;

  prbd_rx_e rx_state_reg;
  logic [7:0] rx_page_reg, rx_off_reg, rx_lo_reg, scratch_page_reg;
  logic [10:0] rx_cnt_reg;
  logic [3:0] rx_flags_reg;

  prbd_tx_e tx_state_reg;
  logic [15:0] tx_addr_reg;
  logic [10:0] tx_left_reg;
  logic [15:0] tx_word_reg;
  logic [7:0] q_page [PRBD_QUEUE_DEPTH];
  logic [10:0] q_len [PRBD_QUEUE_DEPTH];
  logic [2:0] q_wr_reg, q_rd_reg;

  logic [7:0] cur_page, cur_off, link_page;
  logic rx_we, q_full, q_empty, tx_go, fr_ready, fr_done, rx_runt, rx_reject;
  logic [PRBD_WADDR_W-1:0] rx_wa;
  logic [15:0] rx_wd;

  function automatic logic [PRBD_WADDR_W-1:0] prbd_word(input logic [7:0] page, input logic [7:0] off);
    return {page[5:0], off[7:1]};
  endfunction

  function automatic logic [7:0] prbd_ring_next(input logic [7:0] page, input logic [7:0] first,
                                                input logic [7:0] stop);
    logic [7:0] n;
    n = page + 8'h01;
    return (n == stop) ? first : n;
  endfunction

  // ****************************************
  // Receive path
  // ****************************************
  // The first byte of a frame is taken in IDLE, so address it from the write pointer
  assign cur_page = (rx_state_reg == RX_IDLE) ? write_page_pointer_reg : rx_page_reg;
  assign cur_off = (rx_state_reg == RX_IDLE) ? PRBD_HDR_OFFSET : rx_off_reg;
  assign link_page = prbd_ring_next(cur_page, ring_first_page_reg, ring_stop_page_reg);
  assign rx_runt = rx_cnt_reg < PRBD_RUNT_LIMIT;
  assign rx_reject = (rx_runt && !rx_config_reg[PRBD_BIT_ACCEPT_RUNT]) ||
                     ((rx_flags_reg[1] || rx_flags_reg[0]) && !rx_config_reg[PRBD_BIT_ACCEPT_ERR]);

  always_comb
  begin
    rx_we = 1'b0;
    rx_wa = prbd_word(cur_page, cur_off);
    rx_wd = {rx_data, rx_lo_reg};
    unique case (rx_state_reg)
      RX_IDLE, RX_STORE:
      begin
        // Every byte, FCS included, goes to memory in arrival order
        rx_we = rx_valid && cur_off[0];
      end
      RX_END:
      begin
        rx_we = rx_off_reg[0];
        rx_wd = {8'h00, rx_lo_reg};
      end
      RX_HDR0:
      begin
        rx_we = 1'b1;
        rx_wa = prbd_word(write_page_pointer_reg, 8'h00);
        rx_wd = {scratch_page_reg, 2'b00, rx_flags_reg[3], rx_runt, rx_flags_reg[2:0], 1'b1};
        rx_wd[1] = rx_flags_reg[0];
        rx_wd[2] = rx_flags_reg[1];
        rx_wd[0] = !(rx_flags_reg[0] || rx_flags_reg[1] || rx_flags_reg[2] || rx_runt);
      end
      RX_HDR1:
      begin
        rx_we = 1'b1;
        rx_wa = prbd_word(write_page_pointer_reg, 8'h02);
        rx_wd = {5'b00000, rx_cnt_reg};
      end
      default:
      begin
        rx_we = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      rx_state_reg <= RX_IDLE;
      rx_page_reg <= 8'h00;
      rx_off_reg <= 8'h00;
      rx_lo_reg <= 8'h00;
      rx_cnt_reg <= 11'h000;
      rx_flags_reg <= 4'h0;
      scratch_page_reg <= 8'h00;
      rx_accept_pulse <= 1'b0;
      rx_drop_pulse <= 1'b0;
    end
    else
    begin
      rx_accept_pulse <= 1'b0;
      rx_drop_pulse <= 1'b0;
      unique case (rx_state_reg)
        RX_IDLE, RX_STORE:
        begin
          if (rx_valid)
          begin
            rx_lo_reg <= rx_data;
            rx_cnt_reg <= (rx_state_reg == RX_IDLE) ? 11'h001 : rx_cnt_reg + 11'h001;
            rx_off_reg <= cur_off + 8'h01;
            rx_page_reg <= cur_page;
            rx_state_reg <= RX_STORE;
            if (rx_state_reg == RX_IDLE)
            begin
              rx_flags_reg <= 4'h0;
            end
            if (rx_last)
            begin
              rx_flags_reg <= {rx_mcast, rx_mii_err, rx_align_err, rx_crc_err};
              // Next frame begins on the page after the one holding the last byte
              scratch_page_reg <= link_page;
              rx_state_reg <= RX_END;
            end
            else if (cur_off == PRBD_PAGE_LAST_BYTE)
            begin
              if (link_page == read_page_reg)
              begin
                rx_state_reg <= RX_DROP;
              end
              else
              begin
                rx_page_reg <= link_page;
              end
            end
          end
        end
        RX_DROP:
        begin
          // Write pointer is untouched, so earlier frames in the ring survive
          if (rx_valid && rx_last)
          begin
            rx_state_reg <= RX_IDLE;
            rx_drop_pulse <= 1'b1;
          end
        end
        RX_END:
        begin
          if (rx_reject)
          begin
            rx_state_reg <= RX_IDLE;
            rx_drop_pulse <= 1'b1;
          end
          else
          begin
            rx_state_reg <= RX_HDR0;
          end
        end
        RX_HDR0:
        begin
          rx_state_reg <= RX_HDR1;
        end
        RX_HDR1:
        begin
          rx_state_reg <= RX_IDLE;
          rx_accept_pulse <= 1'b1;
        end
        default:
        begin
          rx_state_reg <= RX_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Packet memory
  // ****************************************
  // Receive has priority; a host write waits in the pending register until a cycle with no receive write
  always_ff @(posedge clk_sys)
  begin
    if (rx_we)
    begin
      mem[rx_wa] <= rx_wd;
    end
    else if (host_pend_reg)
    begin
      mem[host_pend_addr_reg] <= host_pend_data_reg;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    tx_word_reg <= mem[tx_addr_reg[13:1]];
  end

  // ****************************************
  // Register port
  // ****************************************
  assign tx_go = reg_wr && (reg_addr == PRBD_OFS_COMMAND) && reg_wdata[PRBD_BIT_TX_GO];

  function automatic logic [15:0] prbd_host_step(input logic [15:0] a, input logic ring,
                                                 input logic [7:0] tx_first, input logic [7:0] rx_first);
    logic [15:0] n;
    n = a + 16'h0002;
    if (ring && (n[15:8] == rx_first) && (a[15:8] == rx_first - 8'h01))
    begin
      n = {tx_first, 8'h00};
    end
    return n;
  endfunction

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      ring_first_page_reg <= PRBD_RST_RING_FIRST;
      ring_stop_page_reg <= PRBD_RST_RING_STOP;
      read_page_reg <= PRBD_RST_RING_FIRST;
      write_page_pointer_reg <= PRBD_RST_RING_FIRST + 8'h01;
      tx_first_page_reg <= PRBD_RST_TX_FIRST;
      tx_length_low_reg <= 8'h00;
      tx_length_high_reg <= 8'h00;
      host_addr_reg <= 16'h0000;
      rx_config_reg <= 2'b00;
      tx_ring_en_reg <= 1'b0;
      queue_en_reg <= 1'b0;
      host_pend_reg <= 1'b0;
      host_pend_addr_reg <= '0;
      host_pend_data_reg <= 16'h0000;
      reg_rdata <= 16'h0000;
    end
    else
    begin
      if (!rx_we)
      begin
        host_pend_reg <= 1'b0;
      end
      if (rx_state_reg == RX_HDR1)
      begin
        write_page_pointer_reg <= scratch_page_reg;
      end
      if (reg_wr)
      begin
        unique case (reg_addr)
          PRBD_OFS_RING_FIRST: ring_first_page_reg <= reg_wdata[7:0];
          PRBD_OFS_RING_STOP: ring_stop_page_reg <= reg_wdata[7:0];
          PRBD_OFS_READ_PAGE: read_page_reg <= reg_wdata[7:0];
          PRBD_OFS_TX_FIRST: tx_first_page_reg <= reg_wdata[7:0];
          PRBD_OFS_TX_LEN_LOW: tx_length_low_reg <= reg_wdata[7:0];
          PRBD_OFS_TX_LEN_HIGH: tx_length_high_reg <= reg_wdata[7:0];
          PRBD_OFS_WRITE_PAGE: write_page_pointer_reg <= reg_wdata[7:0];
          PRBD_OFS_COPY_LOW: host_addr_reg[7:0] <= reg_wdata[7:0];
          PRBD_OFS_COPY_HIGH: host_addr_reg[15:8] <= reg_wdata[7:0];
          PRBD_OFS_RX_CONFIG: rx_config_reg <= reg_wdata[1:0];
          PRBD_OFS_TX_RING: tx_ring_en_reg <= reg_wdata[0];
          PRBD_OFS_QUEUE_EN: queue_en_reg <= reg_wdata[0];
          PRBD_OFS_DATA:
          begin
            host_pend_reg <= 1'b1;
            host_pend_addr_reg <= host_addr_reg[13:1];
            host_pend_data_reg <= reg_wdata;
            host_addr_reg <= prbd_host_step(host_addr_reg, tx_ring_en_reg, tx_first_page_reg,
                                            ring_first_page_reg);
          end
          default:
          begin
          end
        endcase
      end
      reg_rdata <= 16'h0000;
      if (reg_rd)
      begin
        unique case (reg_addr)
          PRBD_OFS_RING_FIRST: reg_rdata <= {8'h00, ring_first_page_reg};
          PRBD_OFS_RING_STOP: reg_rdata <= {8'h00, ring_stop_page_reg};
          PRBD_OFS_READ_PAGE: reg_rdata <= {8'h00, read_page_reg};
          PRBD_OFS_TX_FIRST: reg_rdata <= {8'h00, tx_first_page_reg};
          PRBD_OFS_TX_LEN_LOW: reg_rdata <= {8'h00, tx_length_low_reg};
          PRBD_OFS_TX_LEN_HIGH: reg_rdata <= {8'h00, tx_length_high_reg};
          PRBD_OFS_WRITE_PAGE: reg_rdata <= {8'h00, write_page_pointer_reg};
          PRBD_OFS_COPY_LOW: reg_rdata <= {8'h00, host_addr_reg[7:0]};
          PRBD_OFS_COPY_HIGH: reg_rdata <= {8'h00, host_addr_reg[15:8]};
          PRBD_OFS_RX_CONFIG: reg_rdata <= {14'h0000, rx_config_reg};
          PRBD_OFS_TX_RING: reg_rdata <= {15'h0000, tx_ring_en_reg};
          PRBD_OFS_QUEUE_EN: reg_rdata <= {15'h0000, queue_en_reg};
          PRBD_OFS_STATUS: reg_rdata <= {12'h000, q_empty, tx_state_reg != TX_IDLE, 1'b0,
                                         rx_state_reg != RX_IDLE};
          PRBD_OFS_TX_END_REPORT: reg_rdata <= {8'h00, q_full, tx_end_page_report_reg[6:0]};
          PRBD_OFS_DATA:
          begin
            reg_rdata <= mem[host_addr_reg[13:1]];
            host_addr_reg <= host_addr_reg + 16'h0002;
          end
          default:
          begin
          end
        endcase
      end
    end
  end

  // ****************************************
  // Transmit command queue and fetch
  // ****************************************
  assign q_empty = q_wr_reg == q_rd_reg;
  assign q_full = (q_wr_reg[1:0] == q_rd_reg[1:0]) && (q_wr_reg[2] != q_rd_reg[2]);

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      q_wr_reg <= 3'h0;
    end
    // Without the queue option only one command may be outstanding
    else if (tx_go && !q_full && (queue_en_reg || (q_empty && tx_state_reg == TX_IDLE)))
    begin
      q_page[q_wr_reg[1:0]] <= tx_first_page_reg;
      q_len[q_wr_reg[1:0]] <= {tx_length_high_reg[2:0], tx_length_low_reg};
      q_wr_reg <= q_wr_reg + 3'h1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      tx_state_reg <= TX_IDLE;
      q_rd_reg <= 3'h0;
      tx_addr_reg <= 16'h0000;
      tx_left_reg <= 11'h000;
      tx_end_page_report_reg <= 8'h00;
    end
    else
    begin
      unique case (tx_state_reg)
        TX_IDLE:
        begin
          if (!q_empty)
          begin
            q_rd_reg <= q_rd_reg + 3'h1;
            if (q_len[q_rd_reg[1:0]] != 11'h000)
            begin
              tx_addr_reg <= {q_page[q_rd_reg[1:0]], 8'h00};
              tx_left_reg <= q_len[q_rd_reg[1:0]];
              tx_state_reg <= TX_LOAD;
            end
          end
        end
        TX_LOAD:
        begin
          tx_state_reg <= TX_SEND;
        end
        TX_SEND:
        begin
          if (fr_ready)
          begin
            tx_left_reg <= tx_left_reg - 11'h001;
            if (tx_left_reg == 11'h001)
            begin
              tx_end_page_report_reg <= tx_addr_reg[15:8];
              tx_state_reg <= TX_WAIT;
            end
            else
            begin
              tx_addr_reg <= tx_addr_reg + 16'h0001;
              tx_state_reg <= TX_LOAD;
            end
          end
        end
        TX_WAIT:
        begin
          if (fr_done)
          begin
            tx_state_reg <= TX_IDLE;
          end
        end
      endcase
    end
  end

  prbd_tx_framer u_framer (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .in_valid(tx_state_reg == TX_SEND),
    .in_data(tx_addr_reg[0] ? tx_word_reg[15:8] : tx_word_reg[7:0]),
    .in_last(tx_left_reg == 11'h001),
    .in_ready(fr_ready),
    .line_data(tx_line_data),
    .line_valid(tx_line_valid),
    .line_ready(tx_line_ready),
    .done(fr_done)
  );
endmodule // prbd_ring_dma

// ==== prbd_pkg.sv ====
// Purpose: Constants for the packet buffer ring DMA
// Assumes: 16-bit packet memory of 8k words, 256-byte pages
// Notes: Register offsets are byte addresses on the plain register port
package prbd_pkg;
  // ****************************************
  // Memory and page geometry
  // ****************************************
  localparam int PRBD_MEM_WORDS = 8192;
  localparam int PRBD_WADDR_W = 13;
  localparam logic [7:0] PRBD_HDR_OFFSET = 8'h04;
  localparam logic [7:0] PRBD_PAGE_LAST_BYTE = 8'hff;
  localparam logic [10:0] PRBD_RUNT_LIMIT = 11'h040;
  localparam int PRBD_QUEUE_DEPTH = 4;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [4:0] PRBD_OFS_COMMAND = 5'h00;
  localparam logic [4:0] PRBD_OFS_RING_FIRST = 5'h01;
  localparam logic [4:0] PRBD_OFS_RING_STOP = 5'h02;
  localparam logic [4:0] PRBD_OFS_READ_PAGE = 5'h03;
  localparam logic [4:0] PRBD_OFS_TX_FIRST = 5'h04;
  localparam logic [4:0] PRBD_OFS_TX_LEN_LOW = 5'h05;
  localparam logic [4:0] PRBD_OFS_TX_LEN_HIGH = 5'h06;
  localparam logic [4:0] PRBD_OFS_WRITE_PAGE = 5'h07;
  localparam logic [4:0] PRBD_OFS_COPY_LOW = 5'h08;
  localparam logic [4:0] PRBD_OFS_COPY_HIGH = 5'h09;
  localparam logic [4:0] PRBD_OFS_RX_CONFIG = 5'h0c;
  localparam logic [4:0] PRBD_OFS_TX_RING = 5'h0d;
  localparam logic [4:0] PRBD_OFS_STATUS = 5'h0e;
  localparam logic [4:0] PRBD_OFS_DATA = 5'h10;
  localparam logic [4:0] PRBD_OFS_QUEUE_EN = 5'h1b;
  localparam logic [4:0] PRBD_OFS_TX_END_REPORT = 5'h1c;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int PRBD_BIT_TX_GO = 2;
  localparam int PRBD_BIT_ACCEPT_ERR = 0;
  localparam int PRBD_BIT_ACCEPT_RUNT = 1;
  localparam int PRBD_BIT_QUEUE_FULL = 7;
  localparam logic [7:0] PRBD_RST_RING_FIRST = 8'h0c;
  localparam logic [7:0] PRBD_RST_RING_STOP = 8'h40;
  localparam logic [7:0] PRBD_RST_TX_FIRST = 8'h00;

  // ****************************************
  // Line framing
  // ****************************************
  localparam logic [7:0] PRBD_PREAMBLE_BYTE = 8'h55;
  localparam logic [7:0] PRBD_SFD_BYTE = 8'hd5;
  localparam logic [2:0] PRBD_PREAMBLE_LEN = 3'h7;
  localparam logic [31:0] PRBD_CRC_POLY = 32'hedb88320;
  localparam logic [31:0] PRBD_CRC_INIT = 32'hffffffff;
endpackage

// ==== prbd_tx_framer.sv ====
// Purpose: Wraps fetched frame bytes with preamble, start delimiter and FCS
// Assumes: One byte per accepted line handshake, FCS sent low byte first
// Notes: done pulses in the cycle the last FCS byte is first offered on the line, before it is taken
`timescale 1ns/10ps
module prbd_tx_framer
  import prbd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  input wire logic in_last,
  output logic in_ready,
  output logic [7:0] line_data,
  output logic line_valid,
  input wire logic line_ready,
  output logic done
);
  typedef enum logic [2:0] {FR_IDLE, FR_PRE, FR_SFD, FR_DATA, FR_FCS} prbd_fr_e;

  prbd_fr_e state_reg;
  logic [2:0] cnt_reg;
  logic [31:0] crc_reg;
  logic can_load;

  function automatic logic [31:0] prbd_crc_byte(input logic [31:0] crc, input logic [7:0] data);
    logic [31:0] c;
    c = crc ^ {24'h000000, data};
    for (int i = 0; i < 8; i++)
    begin
      c = c[0] ? ((c >> 1) ^ PRBD_CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

  assign can_load = !line_valid || line_ready;
  assign in_ready = can_load && (state_reg == FR_DATA);

  // ****************************************
  // Framing sequence
  // ****************************************
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      state_reg <= FR_IDLE;
      cnt_reg <= 3'h0;
      crc_reg <= PRBD_CRC_INIT;
      line_valid <= 1'b0;
      line_data <= 8'h00;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (line_valid && line_ready)
      begin
        line_valid <= 1'b0;
      end
      if (can_load)
      begin
        unique case (state_reg)
          FR_IDLE:
          begin
            if (in_valid)
            begin
              state_reg <= FR_PRE;
              cnt_reg <= 3'h0;
              crc_reg <= PRBD_CRC_INIT;
            end
          end
          FR_PRE:
          begin
            line_data <= PRBD_PREAMBLE_BYTE;
            line_valid <= 1'b1;
            cnt_reg <= cnt_reg + 3'h1;
            if (cnt_reg == PRBD_PREAMBLE_LEN - 3'h1)
            begin
              state_reg <= FR_SFD;
            end
          end
          FR_SFD:
          begin
            line_data <= PRBD_SFD_BYTE;
            line_valid <= 1'b1;
            state_reg <= FR_DATA;
          end
          FR_DATA:
          begin
            if (in_valid)
            begin
              line_data <= in_data;
              line_valid <= 1'b1;
              crc_reg <= prbd_crc_byte(crc_reg, in_data);
              if (in_last)
              begin
                state_reg <= FR_FCS;
                cnt_reg <= 3'h0;
              end
            end
          end
          FR_FCS:
          begin
            // Appended FCS is the inverted remainder, low byte first
            line_data <= ~crc_reg[7:0];
            line_valid <= 1'b1;
            crc_reg <= {8'h00, crc_reg[31:8]};
            cnt_reg <= cnt_reg + 3'h1;
            if (cnt_reg == 3'h3)
            begin
              state_reg <= FR_IDLE;
              done <= 1'b1;
            end
          end
        endcase
      end
    end
  end
endmodule // prbd_tx_framer

// ==== prbd_ring_dma_checker.sv ====
// Purpose: Port assertions for the ring DMA
// Assumes: One clock, synchronous active-low reset
// Notes: Bound to the top module
`timescale 1ns/10ps
module prbd_ring_dma_checker
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic rx_valid,
  input wire logic rx_last,
  input wire logic rx_accept_pulse,
  input wire logic rx_drop_pulse,
  input wire logic tx_line_valid,
  input wire logic tx_line_ready,
  input wire logic [7:0] tx_line_data
);
  // ****
  // Assertions
  // ****
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not idle");
  chk_accept_late: assert property (rx_accept_pulse |-> $past(rx_valid && rx_last, 4))
    else $error("accept not four cycles after end");
  chk_drop_cause: assert property (rx_drop_pulse |-> $past(rx_valid && rx_last) || $past(rx_valid && rx_last, 2))
    else $error("drop without frame end");
  chk_frame_outcome: assert property (rx_valid && rx_last |-> ##[1:4] (rx_accept_pulse || rx_drop_pulse))
    else $error("frame end without outcome");
  chk_pulse_single: assert property (rx_accept_pulse |=> !rx_accept_pulse && !rx_drop_pulse)
    else $error("accept pulse too long");
  chk_line_hold: assert property (tx_line_valid && !tx_line_ready |=> tx_line_valid && $stable(tx_line_data))
    else $error("line byte not held");
  chk_preamble_first: assert property ($rose(tx_line_valid) && !$past(tx_line_valid, 2) && !$past(tx_line_valid, 3)
    |-> tx_line_data == 8'h55)
    else $error("frame not opened by preamble");
  chk_no_both: assert property (!(rx_accept_pulse && rx_drop_pulse))
    else $error("accept and drop together");
endmodule // prbd_ring_dma_checker
bind prbd_ring_dma prbd_ring_dma_checker u_chk (.clk_sys, .rst_n, .reg_rd, .reg_rdata, .rx_valid, .rx_last,
  .rx_accept_pulse, .rx_drop_pulse, .tx_line_valid, .tx_line_ready, .tx_line_data);

// ==== prbd_line_sink.sv ====
// Purpose: Line side partner that takes transmit bytes
// Assumes: Byte taken when valid and ready
// Notes: Stall toggles ready so each byte after the first of a frame meets a refusal
`timescale 1ns/10ps
module prbd_line_sink
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic stall,
  input wire logic tx_line_valid,
  input wire logic [7:0] tx_line_data,
  output logic tx_line_ready = 1'b0
);
  logic [7:0] got [0:63];
  int n = 0;
  always @(posedge clk_sys)
  begin
    tx_line_ready <= !rst_n ? 1'b0 : (stall ? !tx_line_ready : 1'b1);
    if (!rst_n)
      n <= 0;
    else if (tx_line_valid && tx_line_ready)
    begin
      got[n[5:0]] <= tx_line_data;
      n <= n + 1;
    end
  end
endmodule // prbd_line_sink

// ==== prbd_ring_dma_tb.sv ====
// Purpose: Self-checking bench for the ring DMA
// Assumes: Byte i of each received frame is i modulo 256
// Notes: Header words read back through the data port
`timescale 1ns/10ps
module prbd_ring_dma_tb;
  logic clk_sys = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, stall = 1'b0;
  logic rx_valid = 1'b0, rx_last = 1'b0, rx_crc_err = 1'b0, rx_align_err = 1'b0, rx_mii_err = 1'b0, rx_mcast = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [7:0] rx_data = 8'h00, tx_line_data;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, acc = 16'h0000, drp = 16'h0000;
  logic rx_accept_pulse, rx_drop_pulse, tx_line_valid, tx_line_ready;
  int num_errors = 0, samples_checked = 0;
  prbd_ring_dma u_dut (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rx_valid, .rx_data,
    .rx_last, .rx_crc_err, .rx_align_err, .rx_mii_err, .rx_mcast, .rx_accept_pulse, .rx_drop_pulse, .tx_line_data,
    .tx_line_valid, .tx_line_ready);
  prbd_line_sink u_sink (.clk_sys, .rst_n, .stall, .tx_line_valid, .tx_line_data, .tx_line_ready);
  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    if (rst_n)
    begin
      acc <= acc + rx_accept_pulse;
      drp <= drp + rx_drop_pulse;
    end
  end
  // ****
  // Bus and frame tasks
  // ****
  task chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task rdchk(input logic [4:0] a, input logic [15:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    chk(reg_rdata, e);
  endtask
  task hdr(input logic [7:0] p, input logic [15:0] w0, input logic [15:0] w1);
    wr(5'h08, 16'h0000);
    wr(5'h09, {8'h00, p});
    rdchk(5'h10, w0);
    rdchk(5'h10, w1);
  endtask
  task rxf(input int n, input logic crc, input logic mc);
    rx_crc_err <= crc;
    rx_mcast <= mc;
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk_sys);
      rx_valid <= 1'b1;
      rx_data <= i[7:0];
      rx_last <= (i == n - 1);
    end
    @(posedge clk_sys);
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    repeat (6) @(posedge clk_sys);
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    logic [7:0] e;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    rdchk(5'h01, 16'h000c);
    rdchk(5'h02, 16'h0040);
    rdchk(5'h1f, 16'h0000);
    rxf(64, 1'b0, 1'b0);
    chk(acc, 16'h0001);
    rdchk(5'h07, 16'h000e);
    hdr(8'h0d, 16'h0e01, 16'h0040);
    rdchk(5'h10, 16'h0100);
    rxf(10, 1'b0, 1'b0);
    chk(drp, 16'h0001);
    rdchk(5'h07, 16'h000e);
    wr(5'h0c, 16'h0001);
    rx_align_err <= 1'b1;
    rx_mii_err <= 1'b1;
    rxf(64, 1'b1, 1'b0);
    rx_align_err <= 1'b0;
    rx_mii_err <= 1'b0;
    hdr(8'h0e, 16'h0f0e, 16'h0040);
    wr(5'h0c, 16'h0000);
    rxf(300, 1'b0, 1'b0);
    hdr(8'h0f, 16'h1101, 16'h012c);
    hdr(8'h10, 16'hfdfc, 16'hfffe);
    $display("receive tests done");
    wr(5'h03, 16'h0012);
    rxf(300, 1'b0, 1'b0);
    chk(drp, 16'h0002);
    rdchk(5'h07, 16'h0011);
    hdr(8'h0d, 16'h0e01, 16'h0040);
    wr(5'h02, 16'h0012);
    wr(5'h03, 16'h0020);
    rxf(64, 1'b0, 1'b1);
    hdr(8'h11, 16'h0c21, 16'h0040);
    rdchk(5'h07, 16'h000c);
    $display("ring tests done");
    wr(5'h08, 16'h0000);
    wr(5'h09, 16'h0001);
    wr(5'h04, 16'h0001);
    wr(5'h10, 16'hbbaa);
    wr(5'h10, 16'hddcc);
    wr(5'h05, 16'h0004);
    wr(5'h1b, 16'h0001);
    stall <= 1'b1;
    wr(5'h00, 16'h0004);
    wr(5'h00, 16'h0004);
    for (int t = 0; t < 3000 && u_sink.n < 32; t++)
      @(posedge clk_sys);
    chk(u_sink.n[15:0], 16'h0020);
    for (int i = 0; i < 12; i++)
    begin
      e = (i < 7) ? 8'h55 : (i == 7) ? 8'hd5 : 8'haa + 8'h11 * (i - 8);
      chk({8'h00, u_sink.got[i]}, {8'h00, e});
      chk({8'h00, u_sink.got[i + 16]}, {8'h00, e});
    end
    rdchk(5'h1c, 16'h0001);
    $display("transmit tests done");
    wr(5'h08, 16'h00fe);
    wr(5'h09, 16'h000b);
    wr(5'h10, 16'h1234);
    rdchk(5'h09, 16'h000c);
    wr(5'h0d, 16'h0001);
    wr(5'h08, 16'h00fe);
    wr(5'h09, 16'h000b);
    wr(5'h10, 16'h1234);
    rdchk(5'h09, 16'h0001);
    rdchk(5'h08, 16'h0000);
    $display("host port tests done");
    end_of_test();
  end
  initial
  begin
    #2000000;
    num_errors++;
    end_of_test();
  end
endmodule // prbd_ring_dma_tb
